/* core/puldc_regs.vh */
// constants of the power-up load check sequencer
`ifndef PULDC_REGS_VH
`define PULDC_REGS_VH
`define PULDC_START_BIT      4
`define PULDC_FLT_GND_BIT    0
`define PULDC_FLT_SUP_BIT    1
`define PULDC_FLT_SHORT_BIT  2
`define PULDC_FLT_OPEN_BIT   3
`define PULDC_STATUS_RESET   5'h00
`define PULDC_FET_RESET      1'b1
`define PULDC_CLK_MHZ        100
`define PULDC_DIAG_MS        100
`define PULDC_DIAG_CYCLES    (`PULDC_DIAG_MS * 1000 * `PULDC_CLK_MHZ)
`endif

/* core/puldc_sync.v */
// two flop synchroniser for a vector of comparator levels
`timescale 1ns/1ns
module puldc_sync #(
  parameter WIDTH = 6
) (
  input  wire             clk_sys, // system clock
  input  wire             rst_b,   // async reset, active low
  input  wire [WIDTH-1:0] d_in,    // asynchronous levels
  output wire [WIDTH-1:0] q_out    // synchronised levels
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;
  // first stage feeds only the second
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_reg <= d_in;
      sync_reg <= meta_reg;
    end
  end
  assign q_out = sync_reg;
endmodule

/* core/puldc_core.v */
// power-up load check sequencer
`timescale 1ns/1ns
`include "puldc_regs.vh"
module puldc_core #(
  parameter [31:0] DIAG_CYCLES = `PULDC_DIAG_CYCLES
) (
  input  wire       clk_sys,            // system clock 100 MHz
  input  wire       rst_b,              // async reset, active low
  input  wire       bus_mode,           // 1: control bus present
  input  wire       start_wr,           // host writes start bit, one cycle
  input  wire       mode_check_en,      // mode selects check, no bus
  input  wire       ramp_cap_full,      // ramp capacitor pin at 98 percent
  input  wire       current_low,        // test current at 2 percent
  input  wire       cmp_short_gnd,      // half bridge out level near ground
  input  wire       cmp_short_sup,      // half bridge out level near supply
  input  wire       cmp_short_load,     // load drop too small
  input  wire       cmp_open_load,      // load drop too large
  output reg  [4:0] load_diag_status_reg, // start bit 4, fault bits 3..0
  output reg        ramp_charge,        // charge ramp capacitor
  output reg        test_current_on,    // test current source enable
  output reg        fet_tristate,       // external drivers tristate
  output reg        alarm_pin_out,      // addr select alarm pin data
  output reg        alarm_pin_oe        // alarm pin driven
);
  // ---------------------------------------------------------------
  // state codes and interval limit
  // ---------------------------------------------------------------
  // one-hot sequencer states
  localparam [3:0]  S_IDLE   = 4'b0001; // waiting for a start
  localparam [3:0]  S_RAMP   = 4'b0010; // ramp capacitor charging
  localparam [3:0]  S_TIME   = 4'b0100; // test current on, interval timed
  localparam [3:0]  S_DECAY  = 4'b1000; // ramp discharge, current decay
  // last counter value of one interval
  localparam [31:0] LAST_CNT = DIAG_CYCLES - 32'h1;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  // sequencer state and interval counter
  reg  [3:0]  state_reg;
  reg  [3:0]  state_next;
  reg  [31:0] cnt_reg;
  reg  [31:0] cnt_next;
  // reading class of the previous cycle
  reg  [3:0]  abn_prev_reg;
  // status and no-bus bookkeeping
  reg  [4:0]  status_next;
  reg         nobus_done_reg;
  reg         nobus_done_next;
  // synchronised comparator levels
  wire [5:0]  sync_q;
  wire [3:0]  abn;
  wire        ramp_ok;
  wire        cur_low;
  wire        any_abn;
  // decoded conditions
  wire        start_req;
  wire        class_same;
  wire        span_full;
  wire        fault_hit;
  wire        clean_done;
  wire        decay_done;

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // true when a one-hot state vector holds the given state
  function in_state;
    input [3:0] state_vec;
    input [3:0] state_code;
    begin
      in_state = |(state_vec & state_code);
    end
  endfunction

  // true once the counter has covered the whole interval
  function interval_full;
    input [31:0] count;
    input [31:0] last;
    begin
      interval_full = (count >= last);
    end
  endfunction

  // ---------------------------------------------------------------
  // comparator synchronisation
  // ---------------------------------------------------------------
  // all analog levels pass two flops before any decision
  puldc_sync #(.WIDTH(6)) u_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .d_in    ({current_low, ramp_cap_full, cmp_open_load, cmp_short_load,
                cmp_short_sup, cmp_short_gnd}),
    .q_out   (sync_q)
  );
  assign abn     = sync_q[3:0];
  assign ramp_ok = sync_q[4];
  assign cur_low = sync_q[5];
  assign any_abn = |abn;

  // ---------------------------------------------------------------
  // start and interval decode
  // ---------------------------------------------------------------
  // start from bus write or, without bus, from mode selection
  assign start_req  = bus_mode ? start_wr : (mode_check_en & ~nobus_done_reg);
  // reading class unchanged since the last cycle
  assign class_same = (abn == abn_prev_reg);
  // same class held for the whole interval
  assign span_full  = in_state(state_reg, S_TIME) & class_same & interval_full(cnt_reg, LAST_CNT);
  // abnormal for the full interval: latch the matching bits
  assign fault_hit  = span_full & any_abn;
  // clean for the full interval: wind down
  assign clean_done = span_full & ~any_abn;
  // test current decayed to its low level
  assign decay_done = in_state(state_reg, S_DECAY) & cur_low;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // next state; a held fault keeps the sequencer timing
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:  if (start_req) state_next = S_RAMP;
      S_RAMP:  if (ramp_ok) state_next = S_TIME;
      S_TIME:  if (clean_done) state_next = S_DECAY;
      S_DECAY: if (decay_done) state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  // interval counter, restarts whenever the reading changes class
  always @*
  begin
    cnt_next = cnt_reg;
    if (!in_state(state_reg, S_TIME))
      cnt_next = 32'h0;
    else if (!class_same)
      cnt_next = 32'h0;
    else if (!interval_full(cnt_reg, LAST_CNT))
      cnt_next = cnt_reg + 32'h1;
  end

  // status bits and no-bus completion flag
  always @*
  begin
    status_next     = load_diag_status_reg;
    nobus_done_next = nobus_done_reg;
    // dropping the mode selection arms a new no-bus run
    if (!mode_check_en)
      nobus_done_next = 1'b0;
    if (in_state(state_reg, S_IDLE) && start_req)
    begin
      // set start, clear old faults
      status_next                   = `PULDC_STATUS_RESET;
      status_next[`PULDC_START_BIT] = 1'b1;
    end
    else if (fault_hit)
      status_next[3:0] = load_diag_status_reg[3:0] | abn;
    else if (decay_done)
    begin
      // host polls this bit for completion
      status_next[`PULDC_START_BIT] = 1'b0;
      // completion wins over a same-cycle mode drop
      if (!bus_mode)
        nobus_done_next = 1'b1;
    end
  end

  // state, counter, class history and status flops
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg            <= S_IDLE;
      cnt_reg              <= 32'h0;
      abn_prev_reg         <= 4'h0;
      load_diag_status_reg <= `PULDC_STATUS_RESET;
      nobus_done_reg       <= 1'b0;
    end
    else
    begin
      state_reg            <= state_next;
      cnt_reg              <= cnt_next;
      abn_prev_reg         <= abn;
      load_diag_status_reg <= status_next;
      nobus_done_reg       <= nobus_done_next;
    end
  end

  // ---------------------------------------------------------------
  // analog controls and pins
  // ---------------------------------------------------------------
  // registered so the analog side never sees decode glitches
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ramp_charge     <= 1'b0;
      test_current_on <= 1'b0;
      fet_tristate    <= `PULDC_FET_RESET;
      alarm_pin_out   <= 1'b0;
      alarm_pin_oe    <= 1'b0;
    end
    else
    begin
      ramp_charge     <= in_state(state_next, S_RAMP | S_TIME); // discharge in decay
      test_current_on <= in_state(state_next, S_TIME);
      fet_tristate    <= !in_state(state_next, S_IDLE) || (!bus_mode && mode_check_en && !nobus_done_reg);
      alarm_pin_oe    <= ~bus_mode;
      alarm_pin_out   <= ~bus_mode && !in_state(state_next, S_IDLE) && (|load_diag_status_reg[3:0]); // low at end
    end
  end
endmodule

/* verification/puldc_core_properties.sv */
// assertions on the load check sequencer ports
`timescale 1ns/1ns
module puldc_core_properties #(parameter [31:0] DIAG_CYCLES = 50) (
  input wire       clk_sys, rst_b, bus_mode, start_wr, mode_check_en, ramp_cap_full, current_low,
  input wire       cmp_short_gnd, cmp_short_sup, cmp_short_load, cmp_open_load,
  input wire [4:0] load_diag_status_reg,
  input wire       ramp_charge, test_current_on, fet_tristate, alarm_pin_out, alarm_pin_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  reg [31:0] clean_reg;
  wire       abn = cmp_short_gnd | cmp_short_sup | cmp_short_load | cmp_open_load;
  // clean cycles with test current on
  always @(posedge clk_sys or negedge rst_b)
    if (!rst_b) clean_reg <= 32'h0;
    else clean_reg <= (test_current_on && !abn) ? clean_reg + 32'h1 : 32'h0;
  sequence s_start; bus_mode && start_wr && !load_diag_status_reg[4]; endsequence
  sequence s_armed; load_diag_status_reg[4] && ramp_charge && fet_tristate; endsequence
  start_seq_a: assert property (s_start |=> s_armed) else $error("start not taken");
  tristate_hold_a: assert property (load_diag_status_reg[4] |-> fet_tristate) else $error("drivers free");
  ramp_gate_a: assert property ($rose(test_current_on) |-> $past(ramp_cap_full, 2)) else $error("early");
  full_interval_a: assert property ($fell(test_current_on) |-> clean_reg >= DIAG_CYCLES - 4)
    else $error("interval short");
  decay_end_a: assert property ($fell(test_current_on) |-> !ramp_charge) else $error("ramp kept");
  clear_late_a: assert property ($fell(load_diag_status_reg[4]) |-> $past(current_low, 2)) else $error("clr");
  fault_timed_a: assert property ($rose(|load_diag_status_reg[3:0]) |-> test_current_on) else $error("flt");
  alarm_show_a: assert property (!bus_mode && load_diag_status_reg[4] && |load_diag_status_reg[3:0] |-> ##[0:2] alarm_pin_out)
    else $error("alarm missing");
  alarm_end_a: assert property (!bus_mode && $fell(fet_tristate) |-> !alarm_pin_out && alarm_pin_oe)
    else $error("alarm at end");
endmodule

/* verification/puldc_load_model.sv */
// far side model: ramp capacitor, test current, comparators
`timescale 1ns/1ns
module puldc_load_model (
  input wire        clk_sys, ramp_charge, test_current_on,
  input wire  [3:0] fault_sel, ramp_len,
  output wire       ramp_cap_full, current_low,
  output wire [3:0] cmp
);
  reg [3:0] ramp_reg = 4'h0;
  reg [3:0] cur_reg = 4'h0;
  // charge ramp, decay current slowly
  always @(posedge clk_sys)
  begin
    ramp_reg <= ramp_charge ? ramp_reg + {3'h0, ramp_reg != 4'hf} : 4'h0;
    cur_reg <= test_current_on ? 4'h8 : cur_reg - {3'h0, cur_reg != 4'h0};
  end
  assign ramp_cap_full = ramp_reg >= ramp_len;
  assign current_low = cur_reg == 4'h0;
  assign cmp = fault_sel & {4{test_current_on}};
endmodule

/* verification/tb_top.sv */
// self-checking bench for the load check sequencer
`timescale 1ns/1ns
module tb_top;
  reg        clk_sys = 0, rst_b = 0, bus_mode = 1, start_wr = 0, mode_check_en = 0;
  reg [3:0]  fault_sel = 0, ramp_len = 4'h3, exp_q[$];
  reg [31:0] seed = 32'h7f75;
  integer    error_cnt = 0, check_count = 0, i, k;
  wire       ramp_cap_full, current_low, cmp_short_gnd, cmp_short_sup, cmp_short_load, cmp_open_load;
  wire       ramp_charge, test_current_on, fet_tristate, alarm_pin_out, alarm_pin_oe;
  wire [4:0] load_diag_status_reg;
  puldc_core #(.DIAG_CYCLES(32'd50)) puldc_core_inst (.*);
  puldc_load_model puldc_load_model_inst (.*, .cmp({cmp_open_load, cmp_short_load, cmp_short_sup, cmp_short_gnd}));
  initial forever #5 clk_sys = ~clk_sys;
  function [31:0] xs(input [31:0] x);
    xs = x ^ (x << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  task final_report;
  begin
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  end
  endtask
  // one check: start, fault for len cycles, poll for end
  task run(input [3:0] code, input integer len, input [3:0] exp);
  begin
    seed = xs(seed);
    exp_q.push_back(exp);
    ramp_len <= seed[3:0];
    start_wr <= bus_mode;
    mode_check_en <= !bus_mode;
    @(posedge clk_sys) start_wr <= bus_mode;
    @(posedge clk_sys) start_wr <= 0;
    repeat (seed[3:0] + 8) @(posedge clk_sys);
    fault_sel <= code;
    repeat (len) @(posedge clk_sys);
    fault_sel <= 0;
    for (i = 0; i < 900 && load_diag_status_reg[4] !== 1'b0; i = i + 1) @(posedge clk_sys);
    mode_check_en <= 0;
    if (i == 900)
    begin
      error_cnt = error_cnt + 1;
      $display("ERROR %0t timeout", $time);
      final_report;
    end
    $display("test %h done", code);
    repeat (4) @(posedge clk_sys);
  end
  endtask
  // compare result with oldest note
  always @(negedge load_diag_status_reg[4]) if (rst_b)
  begin
    #1 check_count = check_count + 1;
    if (exp_q.size() == 0 || load_diag_status_reg[3:0] !== exp_q[0])
    begin
      error_cnt = error_cnt + 1;
      $display("ERROR %0t status %h", $time, load_diag_status_reg);
    end
    if (exp_q.size() != 0) void'(exp_q.pop_front());
  end
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1;
    @(posedge clk_sys);
    run(0, 0, 0);
    for (k = 0; k < 4; k = k + 1) run(4'h1 << k, 60, 4'h1 << k);
    run(4'h8, seed[5:0] % 40 + 1, 0);
    bus_mode <= 0;
    rst_b <= 0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1;
    @(posedge clk_sys);
    run(4'h2, 60, 4'h2);
    run(0, 0, 0);
    final_report;
  end
endmodule
bind puldc_core puldc_core_properties #(.DIAG_CYCLES(DIAG_CYCLES)) puldc_core_properties_inst (.*);
